/* File: fpdid_flash.sv */
// Flash end: decodes sleep, wake/signature and identity reads on the link.
// Assumes the host keeps SPI mode 0 timing; pins are synchronised here.
//
// How it works
// - Only the sleep instruction enters deep sleep.
// - Deselect returns standby unless a cycle runs or the device is not awake.
// - Asleep, only wake instruction is accepted.
// - Reset always leaves the device awake.
// - Sleep executes only if deselected after bit 8.
// - Sleep counts after the entry delay.
// - Sleep during busy cycle is rejected.
// - Identity read sends maker, type, capacity.
// - Identity read ignored while erase/program runs.
// - Output bits change on falling clock edge.
// - Deselect ends output; returns standby only when awake and not busy.
// - Opcode, two dummies, address; sample rising.
// - Maker/part read ignored during erase/program.
// - Wake instruction: three dummies, then signature.
// - Signature returned when awake; ignored when busy.
// - Signature repeats while clocking continues.
// - After full signature, long wake delay.
// - Early deselect uses the short wake delay.
// - Sleep opcode is b9h.
// - Wake opcode is abh.
`timescale 1ns/10ps
`default_nettype none
`include "fpdid_defs.svh"
module fpdid_flash
    import fpdid_pkg::*;
#(
    parameter int SLEEP_CYC = `FPDID_SLEEP_CYC,
    parameter int WAKE_SHORT_CYC = `FPDID_WAKE_SHORT_CYC,
    parameter int WAKE_LONG_CYC = `FPDID_WAKE_LONG_CYC,
    parameter logic [7:0] MAKER = `FPDID_MAKER_CODE,
    parameter logic [7:0] MEM_TYPE = `FPDID_MEM_TYPE,
    parameter logic [7:0] CAPACITY = `FPDID_CAPACITY,
    parameter logic [7:0] PART = `FPDID_PART_CODE
) (
    input  wire logic  clock,
    input  wire logic  nrst,
    fpdid_link_if.flash link,
    input  wire logic  busy_erase_prog,
    input  wire logic  busy_status_wr,
    output var  logic  asleep,
    output var  logic  standby
);
    // Maker, type, capacity and part values above are arbitrary identity codes.
    logic [1:0] cs_s_q, sck_s_q, din_s_q;
    logic cs_q, sck_q;
    logic [5:0] bits_q;
    logic [7:0] op_q;
    logic [7:0] in_q;
    logic [7:0] addr_q;
    logic [23:0] sh_q;
    logic [4:0] out_cnt_q;
    logic sig_done_q;
    logic out_en_q;
    logic [15:0] tmr_q;
    fpdid_pwr_t pwr_q;
    logic cs_rise, cs_fall, sck_rise, sck_fall, any_busy, sel;
    logic [7:0] in_d;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cs_s_q  <= 2'h3;
            sck_s_q <= 2'h0;
            din_s_q <= 2'h0;
            cs_q    <= 1'b1;
            sck_q   <= 1'b0;
        end else begin
            cs_s_q  <= {cs_s_q[0], link.cs_n};
            sck_s_q <= {sck_s_q[0], link.sck};
            din_s_q <= {din_s_q[0], link.serial_input_line};
            cs_q    <= cs_s_q[1];
            sck_q   <= sck_s_q[1];
        end
    end

    assign sel      = !cs_s_q[1];
    assign cs_rise  = cs_s_q[1] && !cs_q;
    assign cs_fall  = !cs_s_q[1] && cs_q;
    assign sck_rise = sel && sck_s_q[1] && !sck_q;
    assign sck_fall = sel && !sck_s_q[1] && sck_q;
    assign any_busy = busy_erase_prog || busy_status_wr;
    assign in_d     = {in_q[6:0], din_s_q[1]};

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            bits_q <= 6'h0;
            in_q   <= 8'h0;
            op_q   <= 8'h0;
            addr_q <= 8'h0;
        end else if (cs_fall) begin
            bits_q <= 6'h0;
        end else if (sck_rise) begin
            in_q <= in_d;
            if (bits_q != 6'h3f) begin
                bits_q <= bits_q + 6'h1;
            end
            if (bits_q == 6'h7) begin
                op_q <= in_d;
            end
            if (bits_q == 6'h1f) begin
                addr_q <= in_d;
            end
        end
    end

    function automatic logic accept(input logic [7:0] op, input logic slp,
                                    input logic busy, input logic ep);
        if (slp) begin
            accept = (op == `FPDID_OP_WAKE_SIG) && !busy;
        end else if (op == `FPDID_OP_JEDEC_ID
                     || op == `FPDID_OP_MAKER_PART) begin
            accept = !ep;
        end else begin
            accept = !busy;
        end
    endfunction

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sh_q       <= 24'h0;
            out_cnt_q  <= 5'h0;
            out_en_q   <= 1'b0;
            sig_done_q <= 1'b0;
        end else if (!sel) begin
            out_en_q   <= 1'b0;
            out_cnt_q  <= 5'h0;
            sig_done_q <= 1'b0;
        end else if (sck_fall && accept(op_q, pwr_q != FPDID_PWR_AWAKE,
                                         any_busy, busy_erase_prog)) begin
            if (bits_q == 6'h8 && op_q == `FPDID_OP_JEDEC_ID) begin
                sh_q      <= {MAKER, MEM_TYPE, CAPACITY};
                out_en_q  <= 1'b1;
                out_cnt_q <= 5'h17;
            end else if (bits_q == 6'h20
                         && op_q == `FPDID_OP_MAKER_PART) begin
                sh_q <= addr_q[0] ? {PART, MAKER, 8'h0}
                                  : {MAKER, PART, 8'h0};
                out_en_q  <= 1'b1;
                out_cnt_q <= 5'hf;
            end else if (bits_q == 6'h20
                         && op_q == `FPDID_OP_WAKE_SIG) begin
                sh_q      <= {PART, 16'h0};
                out_en_q  <= 1'b1;
                out_cnt_q <= 5'h7;
            end else if (out_en_q) begin
                if (out_cnt_q != 5'h0) begin
                    sh_q      <= {sh_q[22:0], 1'b0};
                    out_cnt_q <= out_cnt_q - 5'h1;
                end else if (op_q == `FPDID_OP_WAKE_SIG) begin
                    sh_q       <= {PART, 16'h0};
                    out_cnt_q  <= 5'h7;
                    sig_done_q <= 1'b1;
                end else begin
                    out_en_q <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            link.dout      <= 1'b1;
            link.dout_oe_n <= 1'b1;
        end else begin
            // A released data line idles high, as with a pull-up.
            link.dout      <= out_en_q ? sh_q[23] : 1'b1;
            link.dout_oe_n <= !out_en_q;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pwr_q <= FPDID_PWR_AWAKE;
            tmr_q <= 16'h0;
        end else begin
            case (pwr_q)
                FPDID_PWR_AWAKE: begin
                    if (cs_rise && bits_q == 6'h8 && !any_busy
                        && op_q == `FPDID_OP_SLEEP) begin
                        pwr_q <= FPDID_PWR_ENTERING;
                        tmr_q <= 16'(SLEEP_CYC);
                    end
                end
                FPDID_PWR_ENTERING: begin
                    if (tmr_q <= 16'h1) begin
                        pwr_q <= FPDID_PWR_ASLEEP;
                    end else begin
                        tmr_q <= tmr_q - 16'h1;
                    end
                end
                FPDID_PWR_ASLEEP: begin
                    if (cs_rise && bits_q >= 6'h8
                        && op_q == `FPDID_OP_WAKE_SIG) begin
                        pwr_q <= FPDID_PWR_WAKING;
                        tmr_q <= (sig_done_q || bits_q >= 6'h28)
                                 ? 16'(WAKE_LONG_CYC)
                                 : 16'(WAKE_SHORT_CYC);
                    end
                end
                default: begin
                    if (tmr_q <= 16'h1) begin
                        pwr_q <= FPDID_PWR_AWAKE;
                    end else begin
                        tmr_q <= tmr_q - 16'h1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            asleep  <= 1'b0;
            standby <= 1'b1;
        end else begin
            asleep  <= pwr_q == FPDID_PWR_ASLEEP;
            standby <= !sel && !any_busy && pwr_q == FPDID_PWR_AWAKE;
        end
    end
endmodule
`default_nettype wire

/* File: fpdid_defs.svh */
// Constants for the sleep and identity command ends of the serial flash link.
// Assumes a 20 MHz system clock on both ends.
`ifndef FPDID_DEFS_SVH
`define FPDID_DEFS_SVH
`define FPDID_CLK_NS          50
`define FPDID_OP_SLEEP        8'hb9
`define FPDID_OP_WAKE_SIG     8'hab
`define FPDID_OP_JEDEC_ID     8'h9f
`define FPDID_OP_MAKER_PART   8'h90
`define FPDID_MAKER_CODE      8'ha5
`define FPDID_MEM_TYPE        8'h5a
`define FPDID_CAPACITY        8'h3c
`define FPDID_PART_CODE       8'hc3
`define FPDID_SLEEP_NS        3000
`define FPDID_WAKE_SHORT_NS   1800
`define FPDID_WAKE_LONG_NS    3000
`define FPDID_SLEEP_CYC       ((`FPDID_SLEEP_NS + `FPDID_CLK_NS - 1) / `FPDID_CLK_NS)
`define FPDID_WAKE_SHORT_CYC  ((`FPDID_WAKE_SHORT_NS + `FPDID_CLK_NS - 1) / `FPDID_CLK_NS)
`define FPDID_WAKE_LONG_CYC   ((`FPDID_WAKE_LONG_NS + `FPDID_CLK_NS - 1) / `FPDID_CLK_NS)
`define FPDID_SCK_HALF        8
`endif

/* File: fpdid_pkg.sv */
// Types shared by both ends of the sleep and identity command link.
// Assumes nothing beyond the constants header.
package fpdid_pkg;
    typedef enum logic [1:0] {
        FPDID_CMD_SLEEP,
        FPDID_CMD_WAKE_SIG,
        FPDID_CMD_JEDEC_ID,
        FPDID_CMD_MAKER_PART
    } fpdid_cmd_t;
    typedef enum logic [1:0] {
        FPDID_PWR_AWAKE,
        FPDID_PWR_ENTERING,
        FPDID_PWR_ASLEEP,
        FPDID_PWR_WAKING
    } fpdid_pwr_t;
endpackage

/* File: fpdid_link_if.sv */
// Serial link between the host controller and the flash command end.
// Assumes the flash end holds the data-out line high while its enable is off.
`timescale 1ns/10ps
`default_nettype none
interface fpdid_link_if;
    logic cs_n;
    logic sck;
    logic serial_input_line;
    logic dout;
    logic dout_oe_n;
    modport host (output cs_n, output sck, output serial_input_line,
                  input dout, input dout_oe_n);
    modport flash (input cs_n, input sck, input serial_input_line,
                   output dout, output dout_oe_n);
endinterface
`default_nettype wire

/* File: fpdid_host.sv */
// Host end: runs one sleep, wake/signature or identity command per request.
// Assumes a flash end on the link; the serial clock is made here.
`timescale 1ns/10ps
`default_nettype none
`include "fpdid_defs.svh"
module fpdid_host
    import fpdid_pkg::*;
#(
    parameter int HALF = `FPDID_SCK_HALF,
    parameter int WAKE_HOLD = `FPDID_WAKE_LONG_CYC
) (
    input  wire logic       clock,
    input  wire logic       nrst,
    fpdid_link_if.host      link,
    input  wire logic       req,
    input  wire fpdid_cmd_t cmd,
    input  wire logic [7:0] addr,
    output var  logic       busy,
    output var  logic       done,
    output var  logic [23:0] rdata
);
    typedef enum logic [1:0] {FPDID_H_IDLE, FPDID_H_RUN, FPDID_H_HOLD}
        fpdid_hst_t;
    fpdid_hst_t st_q;
    logic [1:0] dout_s_q;
    logic [7:0] div_q;
    logic [6:0] left_q;
    logic [31:0] tx_q;
    logic [15:0] hold_q;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            dout_s_q <= 2'h0;
        end else begin
            dout_s_q <= {dout_s_q[0], link.dout};
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st_q   <= FPDID_H_IDLE;
            div_q  <= 8'h0;
            left_q <= 7'h0;
            tx_q   <= 32'h0;
            hold_q <= 16'h0;
            busy   <= 1'b0;
            done   <= 1'b0;
            rdata  <= 24'h0;
            link.cs_n <= 1'b1;
            link.sck  <= 1'b0;
            link.serial_input_line <= 1'b0;
        end else begin
            done <= 1'b0;
            case (st_q)
                FPDID_H_IDLE: begin
                    if (req) begin
                        st_q  <= FPDID_H_RUN;
                        busy  <= 1'b1;
                        div_q <= 8'h0;
                        link.cs_n <= 1'b0;
                        case (cmd)
                            FPDID_CMD_SLEEP: begin
                                tx_q   <= {`FPDID_OP_SLEEP, 24'h0};
                                left_q <= 7'd8;
                            end
                            FPDID_CMD_WAKE_SIG: begin
                                tx_q   <= {`FPDID_OP_WAKE_SIG, 24'h0};
                                left_q <= 7'd40;
                            end
                            FPDID_CMD_JEDEC_ID: begin
                                tx_q   <= {`FPDID_OP_JEDEC_ID, 24'h0};
                                left_q <= 7'd32;
                            end
                            default: begin
                                tx_q   <= {`FPDID_OP_MAKER_PART, 16'h0, addr};
                                left_q <= 7'd48;
                            end
                        endcase
                        link.serial_input_line <= 1'b0;
                    end
                end
                FPDID_H_RUN: begin
                    div_q <= div_q + 8'h1;
                    if (div_q == 8'(HALF - 1)) begin
                        link.serial_input_line <= tx_q[31];
                        tx_q <= {tx_q[30:0], 1'b0};
                    end else if (div_q == 8'(2 * HALF - 1)) begin
                        link.sck <= 1'b1;
                        rdata <= {rdata[22:0], dout_s_q[1]};
                    end else if (div_q == 8'(3 * HALF - 1)) begin
                        link.sck <= 1'b0;
                        div_q <= 8'(HALF);
                        // Next bit changes with the falling clock.
                        link.serial_input_line <= tx_q[31];
                        tx_q <= {tx_q[30:0], 1'b0};
                        left_q <= left_q - 7'h1;
                        if (left_q == 7'h1) begin
                            st_q   <= FPDID_H_HOLD;
                            link.cs_n <= 1'b1;
                            hold_q <= 16'(WAKE_HOLD);
                        end
                    end
                end
                default: begin
                    if (hold_q <= 16'h1) begin
                        st_q <= FPDID_H_IDLE;
                        busy <= 1'b0;
                        done <= 1'b1;
                    end else begin
                        hold_q <= hold_q - 16'h1;
                    end
                end
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: fpdid_checker.sv */
// Link checker for the sleep and identity command ends.
// Assumes the bench wires it beside the link interface.
`timescale 1ns/10ps
`default_nettype none
module fpdid_checker (
    input wire logic clock,
    input wire logic nrst,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic dout,
    input wire logic dout_oe_n,
    input wire logic asleep,
    input wire logic standby,
    input wire logic busy_erase_prog,
    input wire logic busy_status_wr
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    a_reset_gives_standby:
        assert property ($rose(nrst) |-> !asleep && standby)
        else $error("not awake in standby after reset");
    a_sleep_after_delay:
        assert property ($rose(asleep) |-> $past(cs_n, 6) && cs_n)
        else $error("sleep entered before the entry delay");
    a_sleep_not_busy:
        assert property ($rose(asleep) |-> !busy_erase_prog && !busy_status_wr)
        else $error("sleep entered during a busy cycle");
    a_wake_on_deselect:
        assert property ($fell(asleep) |-> cs_n)
        else $error("woke while still selected");
    a_out_stable_rise:
        assert property ($rose(sck) && !dout_oe_n |-> $stable(dout))
        else $error("data out moved at a rising clock");
    a_drive_only_selected:
        assert property ($fell(dout_oe_n) |-> !cs_n)
        else $error("data out driven while deselected");
    a_release_on_deselect:
        assert property ($rose(cs_n) |-> ##[0:4] dout_oe_n)
        else $error("data out still driven after deselect");
    a_standby_awake:
        assert property (standby |-> !asleep)
        else $error("standby flagged while asleep");
    a_selected_not_standby:
        assert property (!cs_n [*5] |-> !standby)
        else $error("standby flagged while selected");

    c_sleep: cover property ($rose(asleep));
    c_wake: cover property ($fell(asleep));
    c_drive: cover property ($fell(dout_oe_n));
endmodule
`default_nettype wire

/* File: fpdid_tb.sv */
// Bench joining the host and flash ends over one link.
// Assumes the delays are shortened through the flash parameters.
`timescale 1ns/10ps
`default_nettype none
`include "fpdid_defs.svh"
module fpdid_tb
    import fpdid_pkg::*;
;
    logic        clock;
    logic        nrst;
    logic        req;
    fpdid_cmd_t  cmd;
    logic [7:0]  addr;
    logic        busy;
    logic        done;
    logic [23:0] rdata;
    logic        busy_erase_prog;
    logic        busy_status_wr;
    logic        asleep;
    logic        standby;
    int          error_cnt = 0;
    int          checks = 0;
    localparam logic [7:0] MK = `FPDID_MAKER_CODE;
    localparam logic [7:0] PT = `FPDID_PART_CODE;
    localparam logic [23:0] ID =
        {`FPDID_MAKER_CODE, `FPDID_MEM_TYPE, `FPDID_CAPACITY};

    fpdid_link_if link ();
    fpdid_host #(.HALF(8), .WAKE_HOLD(12)) u_fpdid_host (
        .clock(clock), .nrst(nrst), .link(link), .req(req), .cmd(cmd),
        .addr(addr), .busy(busy), .done(done), .rdata(rdata));
    fpdid_flash #(.SLEEP_CYC(4), .WAKE_SHORT_CYC(4), .WAKE_LONG_CYC(6))
    u_fpdid_flash (
        .clock(clock), .nrst(nrst), .link(link),
        .busy_erase_prog(busy_erase_prog), .busy_status_wr(busy_status_wr),
        .asleep(asleep), .standby(standby));
    fpdid_checker u_fpdid_checker (
        .clock(clock), .nrst(nrst), .cs_n(link.cs_n), .sck(link.sck),
        .dout(link.dout), .dout_oe_n(link.dout_oe_n), .asleep(asleep),
        .standby(standby), .busy_erase_prog(busy_erase_prog),
        .busy_status_wr(busy_status_wr));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic chk_flag(input string what, input logic exp,
                            input logic got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_data(input string what, input logic [23:0] exp,
                            input logic [23:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Issues one command and waits for the host to finish it.
    task automatic run(input fpdid_cmd_t c, input logic [7:0] a);
        int n;
        @(posedge clock);
        req  <= 1'b1;
        cmd  <= c;
        addr <= a;
        @(posedge clock);
        req <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 2000) begin
            @(negedge clock);
            n++;
        end
        chk_flag("done", 1'b1, done);
        repeat (4) @(negedge clock);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        #(50 * 20000);
        error_cnt++;
        $display("BAD watchdog expected finish seen timeout");
        tally_and_finish();
    end

    initial begin
        nrst = 1'b0;
        req = 1'b0;
        cmd = FPDID_CMD_SLEEP;
        addr = 8'h00;
        busy_erase_prog = 1'b0;
        busy_status_wr = 1'b0;
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        @(negedge clock);
        chk_flag("asleep", 1'b0, asleep);
        chk_flag("standby", 1'b1, standby);
        run(FPDID_CMD_JEDEC_ID, 8'h00);
        chk_data("identity", ID, rdata);
        for (int a = 0; a < 2; a++) begin
            run(FPDID_CMD_MAKER_PART, 8'(a));
            chk_data("maker part", {8'h00, a ? {PT, MK} : {MK, PT}},
                     {8'h00, rdata[15:0]});
        end
        run(FPDID_CMD_WAKE_SIG, 8'h00);
        chk_data("signature", {16'h0000, PT}, {16'h0000, rdata[7:0]});
        chk_flag("standby", 1'b1, standby);
        run(FPDID_CMD_SLEEP, 8'h00);
        chk_flag("asleep", 1'b1, asleep);
        run(FPDID_CMD_JEDEC_ID, 8'h00);
        chk_flag("asleep", 1'b1, asleep);
        chk_data("refused read", 24'hffffff, rdata);
        run(FPDID_CMD_WAKE_SIG, 8'h00);
        chk_flag("asleep", 1'b0, asleep);
        chk_data("signature", {16'h0000, PT}, {16'h0000, rdata[7:0]});
        @(posedge clock);
        busy_erase_prog <= 1'b1;
        run(FPDID_CMD_SLEEP, 8'h00);
        chk_flag("asleep", 1'b0, asleep);
        chk_flag("standby", 1'b0, standby);
        run(FPDID_CMD_MAKER_PART, 8'h00);
        chk_flag("asleep", 1'b0, asleep);
        chk_data("refused read", 24'hffffff, rdata);
        run(FPDID_CMD_JEDEC_ID, 8'h00);
        chk_data("refused read", 24'hffffff, rdata);
        @(posedge clock);
        busy_erase_prog <= 1'b0;
        busy_status_wr <= 1'b1;
        run(FPDID_CMD_SLEEP, 8'h00);
        chk_flag("asleep", 1'b0, asleep);
        @(posedge clock);
        busy_status_wr <= 1'b0;
        run(FPDID_CMD_JEDEC_ID, 8'h00);
        chk_data("identity", ID, rdata);
        chk_flag("standby", 1'b1, standby);
        run(FPDID_CMD_SLEEP, 8'h00);
        chk_flag("asleep", 1'b1, asleep);
        @(posedge clock);
        nrst <= 1'b0;
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        @(negedge clock);
        chk_flag("asleep", 1'b0, asleep);
        chk_flag("standby", 1'b1, standby);
        tally_and_finish();
    end
endmodule
`default_nettype wire
